// ### hw/dac_ctrl_pkg.sv
// constants, modes, states and carriers of the converter control core
package dac_ctrl_pkg;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_PREFIX = 6'h26;
    localparam logic [7:0] BCAST_ADDR = 8'h90;
    localparam int ADDR_PREFIX_MSB = 7;
    localparam int ADDR_PREFIX_LSB = 2;
    localparam int ADDR_SEL_BIT = 1;
    localparam int ADDR_RW_BIT = 0;

    // ------------------------------------------------------------
    // control / high byte layout
    // ------------------------------------------------------------
    localparam int HI_ZERO_MSB = 7;
    localparam int HI_ZERO_LSB = 6;
    localparam int PD_HI_BIT = 5;
    localparam int PD_LO_BIT = 4;
    localparam int HI_NIB_MSB = 3;
    localparam int HI_NIB_LSB = 0;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [11:0] CODE_RST = 12'h000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_RST = 4'h0;
    localparam logic [1:0] SEL_SETTLE = 2'h3;

    // ------------------------------------------------------------
    // power-down modes
    // ------------------------------------------------------------
    localparam logic [1:0] PD_NORMAL = 2'h0;
    localparam logic [1:0] PD_1K = 2'h1;
    localparam logic [1:0] PD_100K = 2'h2;
    localparam logic [1:0] PD_HIZ = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK_ADDR = 3'b010,
        ST_HIGH = 3'b011,
        ST_ACK_HIGH = 3'b100,
        ST_LOW = 3'b101,
        ST_ACK_LOW = 3'b110,
        ST_SKIP = 3'b111
    } link_state_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [11:0] code;
    } dac_word_t;

    typedef struct packed {
        logic shutdown;
        logic amp_drive;
        logic term_1k;
        logic term_100k;
        logic term_hiz;
    } out_stage_t;

    localparam dac_word_t WORD_RST = '{mode: PD_NORMAL, code: CODE_RST};
    localparam out_stage_t STAGE_RST = '{shutdown: 1'b0, amp_drive: 1'b1, term_1k: 1'b0,
                                         term_100k: 1'b0, term_hiz: 1'b0};

endpackage : dac_ctrl_pkg

// ### hw/dac_powerdown_mode_control.sv
// two-wire receive-only control core of a 12-bit converter with power-down modes
// Contract
// [R01] power-up loads conversion register with zero
// [R02] zero code held until valid write
// [R03] two-bit field selects four modes
// [R04] field zero: amplifier drives stored code
// [R05] nonzero field: amplifier off, termination chosen
// [R06] any power-down asserts linear circuitry shutdown
// [R07] power-down leaves stored code untouched; a power-down write still stores the code field it carries
// [R08] master waits exit time before using output
// [R09] byte pairs accepted repeatedly until stop
// [R10] master prefers repeated start per write
// [R11] high byte: zeros, mode, data nibble
// [R12] update on acknowledge fall after low byte
// [R13] acknowledge matching prefix, select, write bit
// [R14] mode and data committed together only
`timescale 1ns/100ps

module dac_powerdown_mode_control
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic address_select_pin,
    output logic sda_out,
    output logic sda_oe,
    output dac_ctrl_pkg::dac_word_t dac_word,
    output dac_ctrl_pkg::out_stage_t out_stage,
    output logic update_strobe
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;
    logic sel_m_q, sel_s_q;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            sel_m_q <= 1'b0;
            sel_s_q <= 1'b0;
        end
        else
        begin
            scl_m_q <= scl_in;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_in;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            sel_m_q <= address_select_pin;
            sel_s_q <= sel_m_q;
        end
    end

    logic scl_rise, scl_fall, start_seen, stop_seen;

    assign scl_rise = scl_s_q & ~scl_p_q;
    assign scl_fall = ~scl_s_q & scl_p_q;
    assign start_seen = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_seen = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // ------------------------------------------------------------
    // select pin capture after reset release
    // ------------------------------------------------------------
    logic [1:0] sel_cnt_q, sel_cnt_d;
    logic sel_addr_q, sel_addr_d;
    logic sel_done_q, sel_done_d;

    always_comb
    begin
        sel_cnt_d = sel_cnt_q;
        sel_addr_d = sel_addr_q;
        sel_done_d = sel_done_q;
        if (!sel_done_q)
        begin
            if (sel_cnt_q == dac_ctrl_pkg::SEL_SETTLE)
            begin
                sel_addr_d = sel_s_q; // R13
                sel_done_d = 1'b1;
            end
            else
            begin
                sel_cnt_d = sel_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_cnt_q <= 2'h0;
            sel_addr_q <= 1'b0;
            sel_done_q <= 1'b0;
        end
        else
        begin
            sel_cnt_q <= sel_cnt_d;
            sel_addr_q <= sel_addr_d;
            sel_done_q <= sel_done_d;
        end
    end

    // ------------------------------------------------------------
    // link state, shifter and output commit
    // ------------------------------------------------------------
    dac_ctrl_pkg::link_state_t st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] hi_q, hi_d;
    logic oe_q, oe_d;
    logic strobe_q, strobe_d;
    dac_ctrl_pkg::dac_word_t word_q, word_d;
    dac_ctrl_pkg::out_stage_t stage_q, stage_d;
    logic addr_ok, byte_done;
    logic sda_low_q;

    assign byte_done = scl_fall && (bit_q == dac_ctrl_pkg::BIT_LAST);
    assign addr_ok = sel_done_q && (sh_q[dac_ctrl_pkg::ADDR_RW_BIT] == 1'b0)
                     && (sh_q[dac_ctrl_pkg::ADDR_PREFIX_MSB:dac_ctrl_pkg::ADDR_PREFIX_LSB]
                         == dac_ctrl_pkg::ADDR_PREFIX)
                     && (sh_q[dac_ctrl_pkg::ADDR_SEL_BIT] == sel_addr_q)
                     || (sh_q == dac_ctrl_pkg::BCAST_ADDR);

    always_comb
    begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        hi_d = hi_q;
        oe_d = oe_q;
        strobe_d = 1'b0;
        word_d = word_q; // R02 R07
        // the acknowledge clock carries no data bit
        if (scl_rise && !oe_q && (bit_q != dac_ctrl_pkg::BIT_LAST))
        begin
            sh_d = {sh_q[6:0], sda_s_q};
            bit_d = bit_q + 4'h1;
        end
        case (st_q)
            dac_ctrl_pkg::ST_IDLE:
            begin
                bit_d = dac_ctrl_pkg::BIT_RST;
            end
            dac_ctrl_pkg::ST_ADDR:
            begin
                if (byte_done)
                begin
                    bit_d = dac_ctrl_pkg::BIT_RST;
                    if (addr_ok)
                    begin
                        st_d = dac_ctrl_pkg::ST_ACK_ADDR; // R13
                        oe_d = 1'b1;
                    end
                    else
                    begin
                        st_d = dac_ctrl_pkg::ST_SKIP;
                    end
                end
            end
            dac_ctrl_pkg::ST_ACK_ADDR:
            begin
                if (scl_fall)
                begin
                    oe_d = 1'b0;
                    st_d = dac_ctrl_pkg::ST_HIGH;
                end
            end
            dac_ctrl_pkg::ST_HIGH:
            begin
                if (byte_done)
                begin
                    bit_d = dac_ctrl_pkg::BIT_RST;
                    hi_d = sh_q; // R11
                    oe_d = 1'b1;
                    st_d = dac_ctrl_pkg::ST_ACK_HIGH;
                end
            end
            dac_ctrl_pkg::ST_ACK_HIGH:
            begin
                if (scl_fall)
                begin
                    oe_d = 1'b0;
                    st_d = dac_ctrl_pkg::ST_LOW;
                end
            end
            dac_ctrl_pkg::ST_LOW:
            begin
                if (byte_done)
                begin
                    bit_d = dac_ctrl_pkg::BIT_RST;
                    oe_d = 1'b1;
                    st_d = dac_ctrl_pkg::ST_ACK_LOW;
                end
            end
            dac_ctrl_pkg::ST_ACK_LOW:
            begin
                if (scl_fall)
                begin
                    oe_d = 1'b0;
                    // R12 R14 R11
                    word_d.mode = {hi_q[dac_ctrl_pkg::PD_HI_BIT], hi_q[dac_ctrl_pkg::PD_LO_BIT]};
                    word_d.code = {hi_q[dac_ctrl_pkg::HI_NIB_MSB:dac_ctrl_pkg::HI_NIB_LSB], sh_q};
                    strobe_d = 1'b1;
                    st_d = dac_ctrl_pkg::ST_HIGH; // R09
                end
            end
            dac_ctrl_pkg::ST_SKIP:
            begin
                bit_d = dac_ctrl_pkg::BIT_RST;
            end
            default:
            begin
                st_d = dac_ctrl_pkg::ST_IDLE;
                oe_d = 1'b0;
            end
        endcase
        if (start_seen)
        begin
            st_d = dac_ctrl_pkg::ST_ADDR;
            bit_d = dac_ctrl_pkg::BIT_RST;
            oe_d = 1'b0;
        end
        else if (stop_seen)
        begin
            st_d = dac_ctrl_pkg::ST_IDLE; // R09
            oe_d = 1'b0;
        end
    end

    // output stage follows the committed mode
    always_comb
    begin
        stage_d.shutdown = (word_d.mode != dac_ctrl_pkg::PD_NORMAL); // R06
        stage_d.amp_drive = (word_d.mode == dac_ctrl_pkg::PD_NORMAL); // R04 R05
        stage_d.term_1k = (word_d.mode == dac_ctrl_pkg::PD_1K); // R03 R05
        stage_d.term_100k = (word_d.mode == dac_ctrl_pkg::PD_100K); // R05
        stage_d.term_hiz = (word_d.mode == dac_ctrl_pkg::PD_HIZ); // R05
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= dac_ctrl_pkg::ST_IDLE;
            bit_q <= dac_ctrl_pkg::BIT_RST;
            sh_q <= dac_ctrl_pkg::BYTE_RST;
            hi_q <= dac_ctrl_pkg::BYTE_RST;
            oe_q <= 1'b0;
            strobe_q <= 1'b0;
            word_q <= dac_ctrl_pkg::WORD_RST; // R01
            stage_q <= dac_ctrl_pkg::STAGE_RST;
            sda_low_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            hi_q <= hi_d;
            oe_q <= oe_d;
            strobe_q <= strobe_d;
            word_q <= word_d;
            stage_q <= stage_d;
            sda_low_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // open-drain: only ever pulls low
    assign sda_out = sda_low_q;
    assign sda_oe = oe_q;
    assign dac_word = word_q;
    assign out_stage = stage_q;
    assign update_strobe = strobe_q;

endmodule : dac_powerdown_mode_control

// ### tb/dac_mode_chk.sv
// assertion checker of the converter control core
`timescale 1ns/100ps
module dac_mode_chk
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic address_select_pin,
    input wire logic sda_out,
    input wire logic sda_oe,
    input dac_ctrl_pkg::dac_word_t dac_word,
    input dac_ctrl_pkg::out_stage_t out_stage,
    input wire logic update_strobe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence ack_hold_s;
        sda_oe [*8];
    endsequence
    sequence quiet_s;
        !update_strobe [*8];
    endsequence

    ack_length_a: assert property ($rose(sda_oe) |-> ack_hold_s)
        else $error("acknowledge too short");
    ack_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("acknowledge moved while clock high");
    strobe_gap_a: assert property (update_strobe |=> quiet_s)
        else $error("commit strobe repeated");
    commit_point_a: assert property (update_strobe |-> !sda_oe && !scl_in)
        else $error("commit outside acknowledge fall");
    word_hold_a: assert property (!update_strobe |-> $stable(dac_word))
        else $error("word changed without commit");
    stage_hold_a: assert property (!update_strobe |-> $stable(out_stage))
        else $error("output stage changed without commit");
    shutdown_map_a: assert property (out_stage.shutdown == (dac_word.mode != 2'h0)
        && out_stage.amp_drive == (dac_word.mode == 2'h0))
        else $error("shutdown or amplifier wrong for mode");
    term_map_a: assert property ({out_stage.term_1k, out_stage.term_100k, out_stage.term_hiz}
        == {dac_word.mode == 2'h1, dac_word.mode == 2'h2, dac_word.mode == 2'h3})
        else $error("termination wrong for mode");
endmodule : dac_mode_chk

bind dac_powerdown_mode_control dac_mode_chk chk
(
    .mclk(mclk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .address_select_pin(address_select_pin),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .dac_word(dac_word),
    .out_stage(out_stage),
    .update_strobe(update_strobe)
);

// ### tb/bus_master_model.sv
// two-wire bus master model with a 48 ns serial clock
`timescale 1ns/100ps
module bus_master_model
(
    input wire logic sda,
    output logic scl,
    output logic sda_m
);
    localparam time Q = 12;

    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // data changes only while the clock is low
    task automatic bit_slot(input logic b, output logic s);
        sda_m = b;
        #Q scl = 1'b1;
        #Q s = sda;
        #Q scl = 1'b0;
        #Q;
    endtask : bit_slot

    // also serves as repeated start when issued with no stop before it
    task automatic start_c;
        sda_m = 1'b1;
        #Q scl = 1'b1;
        #Q sda_m = 1'b0;
        #Q scl = 1'b0;
        #Q;
    endtask : start_c

    task automatic stop_c;
        sda_m = 1'b0;
        #Q scl = 1'b1;
        #Q sda_m = 1'b1;
        #Q;
    endtask : stop_c

    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_slot(v[i], s);
        bit_slot(1'b1, s);
        ack = !s;
    endtask : send_byte
endmodule : bus_master_model

// ### tb/dac_powerdown_mode_control_test.sv
// self-checking bench of the converter control core
`timescale 1ns/100ps
module dac_powerdown_mode_control_test;
    logic mclk;
    logic rst_n;
    logic strap;
    logic scl;
    logic sda_m;
    logic sda_w;
    logic sda_out;
    logic sda_oe;
    logic update_strobe;
    dac_ctrl_pkg::dac_word_t dac_word;
    dac_ctrl_pkg::out_stage_t out_stage;
    int fails;
    int comparisons;
    int strobes;
    // power-down exit time the master allows, 2.5 us
    localparam int EXIT_WAIT = 500;

    assign sda_w = sda_oe ? (sda_m & sda_out) : sda_m;

    dac_powerdown_mode_control DUT
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .scl_in(scl),
        .sda_in(sda_w),
        .address_select_pin(strap),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .dac_word(dac_word),
        .out_stage(out_stage),
        .update_strobe(update_strobe)
    );

    bus_master_model far_end
    (
        .sda(sda_w),
        .scl(scl),
        .sda_m(sda_m)
    );

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // counted mid-cycle, clear of the launching edge
    always @(negedge mclk)
        if (update_strobe === 1'b1)
            strobes++;

    task automatic end_sim;
        if (fails == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("BAD %0t got %h exp %h", $time, got, exp);
            fails++;
        end
    endtask : check

    function automatic logic [15:0] stage_of(input logic [1:0] m);
        stage_of = {11'h000, m != 2'h0, m == 2'h0, m == 2'h1, m == 2'h2, m == 2'h3};
    endfunction : stage_of

    task automatic do_reset(input logic s);
        rst_n = 1'b0;
        strap = s;
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        repeat (12) @(negedge mclk);
    endtask : do_reset

    task automatic open_frame(input logic [7:0] adr, input logic exp);
        logic a;
        far_end.start_c();
        far_end.send_byte(adr, a);
        check(16'(a), 16'(exp));
    endtask : open_frame

    task automatic send_pair(input logic [1:0] m, input logic [11:0] c);
        logic a;
        int n;
        n = strobes;
        far_end.send_byte({2'b00, m, c[11:8]}, a);
        check(16'(a), 16'h1);
        far_end.send_byte(c[7:0], a);
        check(16'(a), 16'h1);
        for (int i = 0; i < 12 && strobes == n; i++)
            @(negedge mclk);
        check(16'(strobes - n), 16'h1);
        if (strobes == n)
            end_sim();
        check(16'(dac_word), 16'({m, c}));
        check(16'(out_stage), stage_of(m));
    endtask : send_pair

    task automatic t_address(input logic [7:0] adr, input logic exp);
        logic a;
        logic [15:0] w;
        int n;
        n = strobes;
        w = 16'(dac_word);
        open_frame(adr, exp);
        if (exp)
            send_pair(2'h1, {adr, 4'h5});
        else
        begin
            far_end.send_byte(8'h1F, a);
            far_end.send_byte(8'hFF, a);
            check(16'(strobes - n), 16'h0);
            check(16'(dac_word), w);
        end
        far_end.stop_c();
    endtask : t_address

    task automatic t_modes;
        logic [11:0] codes [4] = '{12'hFFF, 12'h000, 12'h800, 12'h001};
        for (int m = 0; m < 4; m++)
        begin
            open_frame(8'h98, 1'b1);
            send_pair(2'(m), codes[m]);
            far_end.stop_c();
        end
    endtask : t_modes

    task automatic t_multi;
        open_frame(8'h98, 1'b1);
        send_pair(2'h3, 12'hABC);
        send_pair(2'h0, 12'hABC);
        repeat (EXIT_WAIT) @(negedge mclk);
        check(16'(dac_word), 16'h0ABC);
        send_pair(2'h2, 12'h123);
        open_frame(8'h98, 1'b1);
        send_pair(2'h0, 12'h456);
        far_end.stop_c();
    endtask : t_multi

    task automatic t_cut;
        logic a;
        logic [15:0] w;
        int n;
        n = strobes;
        w = 16'(dac_word);
        open_frame(8'h98, 1'b1);
        far_end.send_byte(8'h3F, a);
        far_end.stop_c();
        open_frame(8'h98, 1'b1);
        far_end.send_byte(8'h20, a);
        open_frame(8'h98, 1'b1);
        far_end.stop_c();
        check(16'(dac_word), w);
        check(16'(strobes - n), 16'h0);
    endtask : t_cut

    initial
    begin
        fails = 0;
        comparisons = 0;
        strobes = 0;
        do_reset(1'b0);
        check(16'(dac_word), 16'h0000);
        check(16'(out_stage), stage_of(2'h0));
        t_address(8'h9A, 1'b0);
        t_address(8'h99, 1'b0);
        t_address(8'hD8, 1'b0);
        t_address(8'h98, 1'b1);
        t_address(8'h90, 1'b1);
        t_modes();
        t_multi();
        t_cut();
        @(negedge mclk);
        do_reset(1'b1);
        check(16'(dac_word), 16'h0000);
        t_address(8'h98, 1'b0);
        t_address(8'h9A, 1'b1);
        end_sim();
    end
endmodule : dac_powerdown_mode_control_test
